// ==== include/rgmii_clk_params.svh ====
// Timing and count constants for the tri-speed link clocking block
`ifndef RGMII_CLK_PARAMS_SVH
`define RGMII_CLK_PARAMS_SVH

`define REF_CLK_MHZ 125
`define SYS_CLK_MHZ 200
`define TXC_SKEW_NS 2
// Least time rounds up, and never below one cycle
`define TXC_SKEW_CYC (((`TXC_SKEW_NS * `SYS_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
    ((`TXC_SKEW_NS * `SYS_CLK_MHZ + 999) / 1000))
`define DIV_100M 10
`define DIV_10M 100
`define RATE_CNT_W 7
`define RATE_CNT_RST 7'h00
`define SPEED_RST 2'h2
`define NIB_RST 4'h0
`define BYTE_RST 8'h00

`endif

// ==== include/rgmii_clk_pkg.sv ====
// Types shared by the tri-speed link clocking block
package rgmii_clk_pkg;
    typedef enum logic [1:0] {
        SPEED_10M = 2'b00,
        SPEED_100M = 2'b01,
        SPEED_1G = 2'b10
    } speed_t;

    typedef enum logic [0:0] {
        RX_LOW = 1'b0,
        RX_HIGH = 1'b1
    } rx_phase_t;
endpackage

// ==== hdl/rate_pulse_gen.sv ====
// Rate pulse generator: per-cycle transmit qualifier for the three speeds
`timescale 1ns/1ps
`default_nettype none
`include "rgmii_clk_params.svh"

module rate_pulse_gen (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire rgmii_clk_pkg::speed_t speed_i,
    output logic tick_o,
    output logic [`RATE_CNT_W-1:0] cnt_o
);
    import rgmii_clk_pkg::*;

    logic [`RATE_CNT_W-1:0] cnt_r, cnt_nxt;
    speed_t speed_r, speed_nxt;

    function automatic logic [`RATE_CNT_W-1:0] wrap_of(input speed_t s);
        case (s)
            SPEED_10M: wrap_of = `RATE_CNT_W'(`DIV_10M - 1);
            SPEED_100M: wrap_of = `RATE_CNT_W'(`DIV_100M - 1);
            default: wrap_of = `RATE_CNT_W'(0);
        endcase
    endfunction

    always_comb begin
        cnt_nxt = cnt_r;
        speed_nxt = speed_r;
        if (ce_i) begin
            speed_nxt = speed_i;
            if (speed_i != speed_r) begin
                cnt_nxt = `RATE_CNT_RST;
            end else if (cnt_r >= wrap_of(speed_i)) begin
                cnt_nxt = `RATE_CNT_RST;
            end else begin
                cnt_nxt = cnt_r + `RATE_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= `RATE_CNT_RST;
            speed_r <= SPEED_1G;
        end else begin
            cnt_r <= cnt_nxt;
            speed_r <= speed_nxt;
        end
    end

    // Qualifier is high on count zero: always at 1G, one in ten or one in a hundred
    assign tick_o = (cnt_r == `RATE_CNT_RST);
    assign cnt_o = cnt_r;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    AST_GIG_ALWAYS: assert property (ce_i && speed_i == SPEED_1G |=> tick_o)
        else $error("qualifier low at 1G");
    AST_WRAP_100M: assert property (ce_i && speed_i == SPEED_100M
        && speed_r == SPEED_100M && cnt_r == 7'h09 |=> tick_o)
        else $error("100M count did not wrap at ten");
    AST_WRAP_10M: assert property (ce_i && speed_i == SPEED_10M
        && speed_r == SPEED_10M && cnt_r == 7'h50 |=> !tick_o)
        else $error("10M count wrapped early");
    AST_RESTART: assert property (ce_i && speed_i != speed_r |=> cnt_r == `RATE_CNT_RST)
        else $error("count did not restart on speed change");
    COV_100M_TICK: cover property (speed_i == SPEED_100M && tick_o ##10 tick_o);
endmodule // rate_pulse_gen

`default_nettype wire

// ==== hdl/rgmii_tri_speed_clock_enable.sv ====
// Tri-speed link clocking: transmit qualifier, DDR output halves and receive capture
`timescale 1ns/1ps
`default_nettype none
`include "rgmii_clk_params.svh"

module rgmii_tri_speed_clock_enable (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire rgmii_clk_pkg::speed_t speed_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    input wire logic tx_err_i,
    output logic tx_en_o,
    output logic [3:0] txd_rise_o,
    output logic [3:0] txd_fall_o,
    output logic txctl_rise_o,
    output logic txctl_fall_o,
    output logic txc_rise_o,
    output logic txc_fall_o,
    output logic txc_skew_en_o,
    input wire logic rxc_i,
    input wire logic [3:0] rxd_i,
    input wire logic rxctl_i,
    output logic rx_en_o,
    output logic [7:0] rx_data_o,
    output logic rx_dv_o,
    output logic rx_err_o
);
    import rgmii_clk_pkg::*;

    // ------------------------------------------------------------
    // Transmit qualifier
    // ------------------------------------------------------------
    logic tick;
    logic [`RATE_CNT_W-1:0] cnt;

    // One shared clock at all speeds; the qualifier does the rate work
    rate_pulse_gen u_rate (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .speed_i(speed_i),
        .tick_o(tick),
        .cnt_o(cnt)
    );

    assign tx_en_o = tick;

    // ------------------------------------------------------------
    // Transmit DDR halves
    // ------------------------------------------------------------
    logic [7:0] tx_byte_r, tx_byte_nxt;
    logic tx_dv_r, tx_dv_nxt;
    logic tx_er_r, tx_er_nxt;
    logic [`RATE_CNT_W-1:0] cnt_d_r, cnt_d_nxt;
    logic [3:0] txd_rise_nxt, txd_fall_nxt;
    logic txctl_rise_nxt, txctl_fall_nxt;
    logic txc_rise_nxt, txc_fall_nxt;
    logic skew_nxt;

    // Half-slot h of a byte period of 2n half-slots: which nibble, and clock level
    function automatic logic [1:0] half_slot(input logic [7:0] h, input logic [7:0] n);
        logic [7:0] m;
        m = (h < n) ? h : 8'(h - n);
        half_slot = {h >= n, m < (n >> 1)};
    endfunction

    always_comb begin
        logic [7:0] n;
        logic [1:0] sr;
        logic [1:0] sf;
        n = (speed_i == SPEED_10M) ? 8'(`DIV_10M) : 8'(`DIV_100M);
        sr = half_slot({cnt_d_r, 1'b0}, n);
        sf = half_slot({cnt_d_r, 1'b1}, n);
        tx_byte_nxt = tx_byte_r;
        tx_dv_nxt = tx_dv_r;
        tx_er_nxt = tx_er_r;
        cnt_d_nxt = cnt_d_r;
        txd_rise_nxt = txd_rise_o;
        txd_fall_nxt = txd_fall_o;
        txctl_rise_nxt = txctl_rise_o;
        txctl_fall_nxt = txctl_fall_o;
        txc_rise_nxt = txc_rise_o;
        txc_fall_nxt = txc_fall_o;
        skew_nxt = txc_skew_en_o;
        if (ce_i) begin
            cnt_d_nxt = cnt;
            if (tick) begin
                tx_byte_nxt = tx_data_i;
                tx_dv_nxt = tx_valid_i;
                tx_er_nxt = tx_err_i;
            end
            // Error rides as valid XOR error on the falling half
            txctl_rise_nxt = tx_dv_r;
            txctl_fall_nxt = tx_dv_r ^ tx_er_r;
            if (speed_i == SPEED_1G) begin
                txd_rise_nxt = tx_byte_r[3:0];
                txd_fall_nxt = tx_byte_r[7:4];
                txc_rise_nxt = 1'b1;
                txc_fall_nxt = 1'b0;
                skew_nxt = 1'b1;
            end else begin
                // Same nibble on both halves; clock halves follow the slot position
                txd_rise_nxt = sr[1] ? tx_byte_r[7:4] : tx_byte_r[3:0];
                txd_fall_nxt = sf[1] ? tx_byte_r[7:4] : tx_byte_r[3:0];
                txc_rise_nxt = sr[0];
                txc_fall_nxt = sf[0];
                skew_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_byte_r <= `BYTE_RST;
            tx_dv_r <= 1'b0;
            tx_er_r <= 1'b0;
            cnt_d_r <= `RATE_CNT_RST;
            txd_rise_o <= `NIB_RST;
            txd_fall_o <= `NIB_RST;
            txctl_rise_o <= 1'b0;
            txctl_fall_o <= 1'b0;
            txc_rise_o <= 1'b0;
            txc_fall_o <= 1'b0;
            txc_skew_en_o <= 1'b0;
        end else begin
            tx_byte_r <= tx_byte_nxt;
            tx_dv_r <= tx_dv_nxt;
            tx_er_r <= tx_er_nxt;
            cnt_d_r <= cnt_d_nxt;
            txd_rise_o <= txd_rise_nxt;
            txd_fall_o <= txd_fall_nxt;
            txctl_rise_o <= txctl_rise_nxt;
            txctl_fall_o <= txctl_fall_nxt;
            txc_rise_o <= txc_rise_nxt;
            txc_fall_o <= txc_fall_nxt;
            txc_skew_en_o <= skew_nxt;
        end
    end

    // ------------------------------------------------------------
    // Receive sampling
    // ------------------------------------------------------------
    // Each instance brings its own PHY clock; it is sampled, not shared
    logic [2:0] rxc_s_r, rxc_s_nxt;
    logic rxc_lvl_r, rxc_lvl_nxt;
    logic [3:0] rxd_s1_r, rxd_s2_r, rxd_s3_r;
    logic [3:0] rxd_s1_nxt, rxd_s2_nxt, rxd_s3_nxt;
    logic [2:0] rxctl_s_r, rxctl_s_nxt;
    logic rise_evt, fall_evt;

    // Edges count only once stages two and three agree on the change
    assign rise_evt = ce_i && rxc_s_r[1] && rxc_s_r[2] && !rxc_lvl_r;
    assign fall_evt = ce_i && !rxc_s_r[1] && !rxc_s_r[2] && rxc_lvl_r;

    logic [3:0] lo_nib_r, lo_nib_nxt;
    logic lo_ctl_r, lo_ctl_nxt;
    rx_phase_t phase_r, phase_nxt;
    logic rx_en_nxt;
    logic [7:0] rx_data_nxt;
    logic rx_dv_nxt, rx_err_nxt;

    always_comb begin
        rxc_s_nxt = rxc_s_r;
        rxc_lvl_nxt = rxc_lvl_r;
        rxd_s1_nxt = rxd_s1_r;
        rxd_s2_nxt = rxd_s2_r;
        rxd_s3_nxt = rxd_s3_r;
        rxctl_s_nxt = rxctl_s_r;
        lo_nib_nxt = lo_nib_r;
        lo_ctl_nxt = lo_ctl_r;
        phase_nxt = phase_r;
        rx_en_nxt = rx_en_o;
        rx_data_nxt = rx_data_o;
        rx_dv_nxt = rx_dv_o;
        rx_err_nxt = rx_err_o;
        if (ce_i) begin
            rx_en_nxt = 1'b0;
            rxc_s_nxt = {rxc_s_r[1:0], rxc_i};
            // Settled level follows only once the last two stages agree
            if (rxc_s_r[1] == rxc_s_r[2]) begin
                rxc_lvl_nxt = rxc_s_r[2];
            end
            rxd_s1_nxt = rxd_i;
            rxd_s2_nxt = rxd_s1_r;
            rxd_s3_nxt = rxd_s2_r;
            rxctl_s_nxt = {rxctl_s_r[1:0], rxctl_i};
            if (speed_i == SPEED_1G) begin
                phase_nxt = RX_LOW;
                if (rise_evt) begin
                    lo_nib_nxt = rxd_s3_r;
                    lo_ctl_nxt = rxctl_s_r[2];
                end else if (fall_evt) begin
                    rx_data_nxt = {rxd_s3_r, lo_nib_r};
                    rx_dv_nxt = lo_ctl_r;
                    rx_err_nxt = lo_ctl_r ^ rxctl_s_r[2];
                    rx_en_nxt = 1'b1;
                end
            end else if (rise_evt) begin
                // One nibble per clock: a byte every second rising edge
                if (phase_r == RX_LOW) begin
                    lo_nib_nxt = rxd_s3_r;
                    lo_ctl_nxt = rxctl_s_r[2];
                    phase_nxt = RX_HIGH;
                end else begin
                    rx_data_nxt = {rxd_s3_r, lo_nib_r};
                    rx_dv_nxt = lo_ctl_r;
                    rx_err_nxt = 1'b0;
                    rx_en_nxt = 1'b1;
                    phase_nxt = RX_LOW;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rxc_s_r <= 3'h0;
            rxc_lvl_r <= 1'b0;
            rxd_s1_r <= `NIB_RST;
            rxd_s2_r <= `NIB_RST;
            rxd_s3_r <= `NIB_RST;
            rxctl_s_r <= 3'h0;
            lo_nib_r <= `NIB_RST;
            lo_ctl_r <= 1'b0;
            phase_r <= RX_LOW;
            rx_en_o <= 1'b0;
            rx_data_o <= `BYTE_RST;
            rx_dv_o <= 1'b0;
            rx_err_o <= 1'b0;
        end else begin
            rxc_s_r <= rxc_s_nxt;
            rxc_lvl_r <= rxc_lvl_nxt;
            rxd_s1_r <= rxd_s1_nxt;
            rxd_s2_r <= rxd_s2_nxt;
            rxd_s3_r <= rxd_s3_nxt;
            rxctl_s_r <= rxctl_s_nxt;
            lo_nib_r <= lo_nib_nxt;
            lo_ctl_r <= lo_ctl_nxt;
            phase_r <= phase_nxt;
            rx_en_o <= rx_en_nxt;
            rx_data_o <= rx_data_nxt;
            rx_dv_o <= rx_dv_nxt;
            rx_err_o <= rx_err_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    AST_TXC_GIG: assert property (ce_i && speed_i == SPEED_1G
        |=> txc_rise_o && !txc_fall_o && txc_skew_en_o)
        else $error("forwarded clock halves wrong at 1G");
    // Byte taken two edges back, out of reset, and split at 1G on the last edge
    AST_TXD_GIG: assert property ($past(ce_i) && $past(ce_i, 2) && $past(tick, 2)
        && !$past(rst_i) && !$past(rst_i, 2) && $past(speed_i) == SPEED_1G
        |-> txd_rise_o == $past(tx_data_i[3:0], 2) && txd_fall_o == $past(tx_data_i[7:4], 2))
        else $error("1G byte not split low nibble first");
    AST_TXD_SLOW_SDR: assert property (ce_i && speed_i != SPEED_1G |=> txd_rise_o == txd_fall_o)
        else $error("slow speed nibble differs between halves");
    AST_RX_EN_PULSE: assert property (ce_i && rx_en_o |=> !rx_en_o)
        else $error("receive qualifier longer than one cycle");
    AST_RX_EN_CAUSE: assert property ($rose(rx_en_o) |-> $past(rise_evt || fall_evt))
        else $error("receive qualifier without a receive clock edge");
    AST_SKEW_SLOW: assert property (ce_i && speed_i != SPEED_1G |=> !txc_skew_en_o)
        else $error("skew enabled at a slow speed");
    COV_GIG_RX: cover property (speed_i == SPEED_1G && rx_en_o);
    COV_SLOW_RX: cover property (speed_i == SPEED_10M && rx_en_o);
endmodule // rgmii_tri_speed_clock_enable

`default_nettype wire

// ==== bench/phy_rx_model.sv ====
// Link partner model: drives the receive clock, nibbles and control toward the block
`timescale 1ns/1ps
`default_nettype none
module phy_rx_model (
    output logic rxc_o,
    output logic [3:0] rxd_o,
    output logic rxctl_o
);
    import rgmii_clk_pkg::*;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    // Quarter of the 80 ns receive clock period
    localparam realtime Q = 20.0;
    initial begin
        rxc_o = 1'b0;
        rxd_o = 4'hF;
        rxctl_o = 1'b0;
    end
    // ----------------------------------------
    // Transfers
    // ----------------------------------------
    task automatic put(input logic [3:0] nib, input logic ctl);
        rxd_o = nib;
        rxctl_o = ctl;
    endtask
    // One edge pair per nibble at the slow rates, one edge per nibble at 1G
    task automatic send_byte(input speed_t spd, input logic [7:0] b, input logic dv,
                             input logic er);
        if (spd == SPEED_1G) begin
            put(b[3:0], dv);
            #Q rxc_o = 1'b1;
            #Q put(b[7:4], dv ^ er);
            #Q rxc_o = 1'b0;
            #Q;
        end else begin
            put(b[3:0], dv);
            #Q rxc_o = 1'b1;
            #(2 * Q) rxc_o = 1'b0;
            #Q put(b[7:4], dv);
            #Q rxc_o = 1'b1;
            #(2 * Q) rxc_o = 1'b0;
            #Q;
        end
    endtask
    // Clock stands still; lines show the inverse so stale data never looks valid
    task automatic idle();
        put(~rxd_o, ~rxctl_o);
    endtask
endmodule // phy_rx_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the tri-speed link clocking block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rgmii_clk_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    speed_t speed = SPEED_1G;
    logic [7:0] tx_data = 8'h3C;
    logic tx_valid = 1'b1;
    logic tx_err = 1'b0;
    logic tx_en, txctl_rise, txctl_fall, txc_rise, txc_fall, txc_skew_en;
    logic [3:0] txd_rise, txd_fall, rxd;
    logic rxc, rxctl, rx_en, rx_dv, rx_err;
    logic [7:0] rx_data;
    int n_mismatch = 0;
    int n_tests = 0;

    always #2.5 sys_clk = ~sys_clk;

    rgmii_tri_speed_clock_enable i_rgmii_tri_speed_clock_enable (
        .sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce), .speed_i(speed),
        .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_err_i(tx_err), .tx_en_o(tx_en),
        .txd_rise_o(txd_rise), .txd_fall_o(txd_fall), .txctl_rise_o(txctl_rise),
        .txctl_fall_o(txctl_fall), .txc_rise_o(txc_rise), .txc_fall_o(txc_fall),
        .txc_skew_en_o(txc_skew_en), .rxc_i(rxc), .rxd_i(rxd), .rxctl_i(rxctl),
        .rx_en_o(rx_en), .rx_data_o(rx_data), .rx_dv_o(rx_dv), .rx_err_o(rx_err)
    );
    phy_rx_model i_phy_rx_model (.rxc_o(rxc), .rxd_o(rxd), .rxctl_o(rxctl));

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic finish_test();
        $display("Counts: tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Two bytes back to back at 1G, the second errored, then one without valid
    task automatic t_tx_1g();
        @(negedge sys_clk) tx_data = 8'hA5;
        @(negedge sys_clk) tx_data = 8'h3E;
        tx_err = 1'b1;
        @(negedge sys_clk);
        chk({8'h00, txd_fall, txd_rise}, 16'h00A5);
        chk({14'h0000, txctl_rise, txctl_fall}, 16'h0003);
        tx_valid = 1'b0;
        tx_err = 1'b0;
        @(negedge sys_clk);
        chk({8'h00, txd_fall, txd_rise}, 16'h003E);
        chk({14'h0000, txctl_rise, txctl_fall}, 16'h0002);
        chk({14'h0000, txc_rise, txc_fall}, 16'h0002);
        @(negedge sys_clk);
        chk({14'h0000, txctl_rise, txctl_fall}, 16'h0000);
        tx_data = 8'h3C;
        tx_valid = 1'b1;
    endtask
    // Qualifier spacing, forwarded clock duty and nibble order over ten byte periods
    task automatic t_rate(input speed_t spd, input int n);
        int ens;
        int clks;
        int lows;
        @(negedge sys_clk) speed = spd;
        @(negedge sys_clk);
        chk(16'(tx_en), 16'h0001);
        repeat (3) @(negedge sys_clk);
        ens = 0;
        clks = 0;
        lows = 0;
        repeat (10 * n) begin
            @(negedge sys_clk);
            ens += int'(tx_en === 1'b1);
            clks += int'(txc_rise === 1'b1) + int'(txc_fall === 1'b1);
            lows += int'(txd_rise === 4'hC);
            if (n > 1) chk({12'h000, txd_rise}, {12'h000, txd_fall});
        end
        chk(16'(ens), 16'h000A);
        chk(16'(clks), 16'(10 * n));
        chk(16'(lows), 16'((n == 1) ? 10 : 5 * n));
        chk(16'(txc_skew_en), 16'((n == 1) ? 1 : 0));
    endtask
    task automatic rx_wait(input logic [7:0] b, input logic er);
        int k;
        k = 0;
        while (rx_en !== 1'b1 && k < 200) begin
            @(negedge sys_clk);
            k++;
        end
        if (rx_en !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end else begin
            chk({8'h00, rx_data}, {8'h00, b});
            chk({14'h0000, rx_dv, rx_err}, {14'h0000, 1'b1, er});
            @(negedge sys_clk);
            chk(16'(rx_en), 16'h0000);
        end
    endtask
    // Two-byte frame from the partner, each byte announced by a single pulse
    task automatic t_rx(input speed_t spd, input logic [7:0] b0, input logic [7:0] b1);
        @(negedge sys_clk) speed = spd;
        fork
            begin
                i_phy_rx_model.send_byte(spd, b0, 1'b1, 1'b1);
                i_phy_rx_model.send_byte(spd, b1, 1'b1, 1'b0);
                i_phy_rx_model.idle();
            end
            begin
                rx_wait(b0, spd == SPEED_1G);
                rx_wait(b1, 1'b0);
            end
        join
    endtask
    // Disabled clock freezes the qualifier and the data and clock output halves
    task automatic t_freeze();
        logic [10:0] snap;
        @(negedge sys_clk) speed = SPEED_10M;
        repeat (7) @(negedge sys_clk);
        ce = 1'b0;
        snap = {tx_en, txd_rise, txd_fall, txc_rise, txc_fall};
        repeat (20) @(negedge sys_clk);
        chk({5'h00, tx_en, txd_rise, txd_fall, txc_rise, txc_fall}, {5'h00, snap});
        ce = 1'b1;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(16'(tx_en), 16'h0001);
        chk({7'h00, rx_en, txd_rise, txd_fall}, 16'h0000);
        rst = 1'b0;
        t_tx_1g();
        t_rate(SPEED_100M, 10);
        t_rate(SPEED_10M, 100);
        t_rate(SPEED_1G, 1);
        t_rx(SPEED_1G, 8'h5A, 8'hC3);
        t_rx(SPEED_100M, 8'h96, 8'h0F);
        t_rx(SPEED_10M, 8'hE1, 8'h78);
        t_freeze();
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
